/* File: mpfm_ext_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module mpfm_ext_mem (
  input wire logic sys_clk, // E clock
  input wire logic [7:0] port_b_lines, // High address
  input wire logic [7:0] port_c_lines, // Address then data
  input wire logic [7:0] port_c_oe_b, // Port C enable
  input wire logic [7:0] port_d_lines, // Strobe and rw
  input wire logic [7:0] port_d_oe_b, // Strobe and rw enables
  output logic [7:0] port_c_in // Data returned on port C
);
  // ==========================================================================
  // Demultiplexed memory
  logic [7:0] mem [256];
  logic [15:0] adr = 16'h0000;
  logic [7:0] lastv = 8'h00;
  wire strobe = port_d_lines[6] && !port_d_oe_b[6];
  wire rdEn = port_d_lines[7] && !port_d_oe_b[7] && !strobe && port_c_oe_b == 8'hff;
  wire wrEn = !port_d_lines[7] && !port_d_oe_b[7] && !strobe && port_c_oe_b == 8'h00;
  // Released bus shows a changing pattern, never the last value
  assign port_c_in = rdEn ? mem[adr[7:0]] : ~lastv;
  always @(posedge sys_clk) begin
    if (strobe) begin
      adr <= {port_b_lines, port_c_lines};
    end
    if (wrEn) begin
      mem[adr[7:0]] <= port_c_lines;
    end
    lastv <= port_c_in;
  end
endmodule
`default_nettype wire

/* File: mpfm_pin_mux.sv */
// Function
// - Sample two mode pins at reset release; hold one of four modes.
// - Mode bits are special flag and select A; encodes four modes.
// - Mode bits captured at reset rise; software may rewrite them.
// - Fetch indicator open-drain low for first cycle of each instruction.
// - Single-chip and bootstrap: read/write pin is port D bit 7.
// - Expanded and test: read/write pin shows bus transfer direction.
// - Single-chip and bootstrap: strobe pin is port D bit 6.
// - Expanded and test: address strobe separates low address from data.
// - Thirty-two lines in four 8-bit ports; B, C, D bidirectional.
// - Port A: two bidirectional, three input-only, three output-only lines.
// - Ports B, C and D6, D7 are general I/O only in single-chip/bootstrap.
// - Expanded and test: port B bits carry address bits 8 to 15.
// - Expanded and test: port C carries low address then data.
// - Port A alternates with captures, compares and pulse accumulator.
// - Port D0 receive, D2 MISO, D3 MOSI in every mode.
// - Unbonded compare pins still run as internal timers.
`timescale 1ns/100ps
`default_nettype none
module mpfm_pin_mux import mpfm_pkg::*; #(
  parameter int W = PORT_WIDTH
) (
  input wire logic sys_clk,              // E clock
  input wire logic rst_b,                // Chip reset, active low
  input wire logic mode_select_a,        // Mode pin A
  input wire logic mode_select_b,        // Mode pin B
  input wire logic mode_wr,              // Software mode bits write strobe
  input wire logic [1:0] mode_wdata,     // {special, A} new mode bits
  output logic special_mode_bit,         // Latched special flag
  output logic mode_a_latch_bit,         // Latched A bit
  input wire logic instr_first_cycle,    // CPU first cycle of instruction
  output logic instr_fetch_strobe_n,     // Fetch indicator level
  output logic instr_fetch_oe_b,         // Fetch indicator enable, low drives
  input wire logic [15:0] bus_addr,      // CPU bus address
  input wire logic [W-1:0] bus_wdata,    // CPU write data
  input wire logic bus_read,             // Transfer is a read
  input wire logic bus_addr_phase,       // Address phase of bus cycle
  output logic [W-1:0] bus_rdata,        // External read data
  input wire logic [W-1:0] port_a_gpio_out, // Port A GPIO data
  input wire logic [W-1:0] port_a_gpio_dir, // Port A GPIO direction, 1 out
  input wire logic [W-1:0] port_b_gpio_out, // Port B GPIO data
  input wire logic [W-1:0] port_b_gpio_dir, // Port B direction
  input wire logic [W-1:0] port_c_gpio_out, // Port C GPIO data
  input wire logic [W-1:0] port_c_gpio_dir, // Port C direction
  input wire logic [W-1:0] port_d_gpio_out, // Port D GPIO data
  input wire logic [W-1:0] port_d_gpio_dir, // Port D direction
  input wire logic [5:1] compare_out,    // Compare outputs 1 to 5
  input wire logic [4:0] compare_1_en,   // Compare 1 drive on port A3..A7
  input wire logic [3:0] compare_pin_en, // Compares 5,4,3,2 pin enables
  input wire logic capture_4_select,     // Port A3 is capture 4
  input wire logic serial_tx,            // Serial transmit data
  input wire logic serial_tx_en,         // Transmitter enabled
  input wire logic spi_mosi_out,         // SPI master out
  input wire logic spi_miso_out,         // SPI slave out
  input wire logic spi_sck_out,          // SPI clock out
  input wire logic spi_en,               // SPI enabled
  input wire logic spi_master,           // SPI is master
  input wire logic [W-1:0] port_a_in,    // Port A pin level
  input wire logic [W-1:0] port_b_in,    // Port B pin level
  input wire logic [W-1:0] port_c_in,    // Port C pin level
  input wire logic [W-1:0] port_d_in,    // Port D pin level
  output logic [W-1:0] port_a_lines,     // Port A drive
  output logic [W-1:0] port_a_oe_b,      // Port A enable, low drives
  output logic [W-1:0] port_b_lines,     // Port B drive
  output logic [W-1:0] port_b_oe_b,      // Port B enable, low drives
  output logic [W-1:0] port_c_lines,     // Port C drive
  output logic [W-1:0] port_c_oe_b,      // Port C enable, low drives
  output logic [W-1:0] port_d_lines,     // Port D drive
  output logic [W-1:0] port_d_oe_b,      // Port D enable, low drives
  output logic [W-1:0] port_a_sync,      // Synced port A levels
  output logic [W-1:0] port_b_sync,      // Synced port B levels
  output logic [W-1:0] port_c_sync,      // Synced port C levels
  output logic [W-1:0] port_d_sync,      // Synced port D levels
  output logic [2:0] capture_in,         // Captures 3,2,1 from A0..A2
  output logic capture_in_4,             // Capture 4 from A3
  output logic pulse_accum_in,           // Pulse accumulator from A7
  output logic serial_rx,                // Serial receive from D0
  output logic spi_miso_in,              // MISO from D2
  output logic spi_mosi_in,              // MOSI from D3
  output logic spi_sck_in,               // SPI clock from D4
  output logic spi_ss_in                 // Slave select from D5
);
  // ==========================================================================
  // Input synchronisers
  logic [4*W+1:0] syncOut;
  logic modeASync;
  logic modeBSync;
  logic [W-1:0] paSync;
  logic [W-1:0] pbSync;
  logic [W-1:0] pcSync;
  logic [W-1:0] pdSync;

  mpfm_sync #(.WIDTH(4*W+2)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .din({mode_select_b, mode_select_a, port_d_in, port_c_in, port_b_in, port_a_in}),
    .dout(syncOut)
  );
  assign paSync = syncOut[W-1:0];
  assign pbSync = syncOut[2*W-1:W];
  assign pcSync = syncOut[3*W-1:2*W];
  assign pdSync = syncOut[4*W-1:3*W];
  assign modeASync = syncOut[4*W];
  assign modeBSync = syncOut[4*W+1];

  // ==========================================================================
  // Mode latch
  logic resetDone;
  logic [1:0] modeBits;
  logic [1:0] next_modeBits;
  mpfm_mode_e mode;
  wire expandedBus;

  // Capture on the first edge after release, from synced pins
  assign next_modeBits = !resetDone ? {~modeBSync, modeASync} :
                         mode_wr ? mode_wdata : modeBits;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      resetDone <= 1'b0;
      modeBits <= MODE_BITS_RESET;
    end else begin
      resetDone <= 1'b1;
      modeBits <= next_modeBits;
    end
  end
  always_comb begin
    case (modeBits)
      2'h0: mode = MPFM_SINGLE_CHIP;
      2'h1: mode = MPFM_EXPANDED;
      2'h2: mode = MPFM_BOOTSTRAP;
      default: mode = MPFM_TEST;
    endcase
  end
  assign expandedBus = (mode == MPFM_EXPANDED) || (mode == MPFM_TEST);
  assign special_mode_bit = modeBits[SPECIAL_MODE_POS];
  assign mode_a_latch_bit = modeBits[MODE_A_LATCH_POS];

  // ==========================================================================
  // Port A: A0..A2 inputs, A3 and A7 bidirectional, A4..A6 outputs
  wire [W-1:0] paAltOut;
  wire [W-1:0] paAltEn;
  wire [W-1:0] paDirOk;
  wire [W-1:0] next_paOut;
  wire [W-1:0] next_paOeB;

  assign paAltOut[2:0] = 3'h0;
  assign paAltEn[2:0] = 3'h0;
  assign paAltOut[3] = compare_1_en[0] ? compare_out[1] : compare_out[5];
  assign paAltEn[3] = compare_1_en[0] | (compare_pin_en[3] & ~capture_4_select);
  assign paAltOut[4] = compare_1_en[1] ? compare_out[1] : compare_out[4];
  assign paAltEn[4] = compare_1_en[1] | compare_pin_en[2];
  assign paAltOut[5] = compare_1_en[2] ? compare_out[1] : compare_out[3];
  assign paAltEn[5] = compare_1_en[2] | compare_pin_en[1];
  assign paAltOut[6] = compare_1_en[3] ? compare_out[1] : compare_out[2];
  assign paAltEn[6] = compare_1_en[3] | compare_pin_en[0];
  assign paAltOut[7] = compare_out[1];
  assign paAltEn[7] = compare_1_en[4];
  assign paDirOk = (port_a_gpio_dir & W'(PA_BIDIR_MASK)) | W'(PA_OUT_MASK);
  assign next_paOut = (paAltEn & paAltOut) | (~paAltEn & port_a_gpio_out);
  assign next_paOeB = ~((paAltEn | paDirOk) & ~W'(PA_IN_MASK));

  // ==========================================================================
  // Ports B and C: GPIO or expansion bus
  wire [W-1:0] next_pbOut;
  wire [W-1:0] next_pbOeB;
  wire [W-1:0] next_pcOut;
  wire [W-1:0] next_pcOeB;
  wire pcDrive;

  assign next_pbOut = expandedBus ? bus_addr[15:8] : port_b_gpio_out;
  assign next_pbOeB = expandedBus ? '0 : ~port_b_gpio_dir;
  assign pcDrive = bus_addr_phase | ~bus_read;
  assign next_pcOut = !expandedBus ? port_c_gpio_out :
                      bus_addr_phase ? bus_addr[7:0] : bus_wdata;
  assign next_pcOeB = expandedBus ? {W{~pcDrive}} : ~port_c_gpio_dir;

  // ==========================================================================
  // Port D: serial, SPI and bus control
  logic [W-1:0] pdAltOut;
  logic [W-1:0] pdAltEn;
  wire [W-1:0] next_pdOut;
  wire [W-1:0] next_pdOeB;

  always_comb begin
    pdAltOut = '0;
    pdAltEn = '0;
    pdAltOut[PD_TX_POS] = serial_tx;
    pdAltEn[PD_TX_POS] = serial_tx_en;
    pdAltOut[PD_MISO_POS] = spi_miso_out;
    pdAltEn[PD_MISO_POS] = spi_en & ~spi_master;
    pdAltOut[PD_MOSI_POS] = spi_mosi_out;
    pdAltEn[PD_MOSI_POS] = spi_en & spi_master;
    pdAltOut[PD_SCK_POS] = spi_sck_out;
    pdAltEn[PD_SCK_POS] = spi_en & spi_master;
    pdAltOut[PD_STROBE_POS] = bus_addr_phase;
    pdAltEn[PD_STROBE_POS] = expandedBus;
    pdAltOut[PD_RW_POS] = bus_read;
    pdAltEn[PD_RW_POS] = expandedBus;
  end
  assign next_pdOut = (pdAltEn & pdAltOut) | (~pdAltEn & port_d_gpio_out);
  assign next_pdOeB = ~(pdAltEn | port_d_gpio_dir);

  // ==========================================================================
  // Registered pin drives
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_lines <= RESET_DATA;
      port_a_oe_b <= RESET_OE_B;
      port_b_lines <= RESET_DATA;
      port_b_oe_b <= RESET_OE_B;
      port_c_lines <= RESET_DATA;
      port_c_oe_b <= RESET_OE_B;
      port_d_lines <= RESET_DATA;
      port_d_oe_b <= RESET_OE_B;
    end else begin
      port_a_lines <= next_paOut;
      port_a_oe_b <= next_paOeB;
      port_b_lines <= next_pbOut;
      port_b_oe_b <= next_pbOeB;
      port_c_lines <= next_pcOut;
      port_c_oe_b <= next_pcOeB;
      port_d_lines <= next_pdOut;
      port_d_oe_b <= next_pdOeB;
    end
  end

  // Fetch indicator: open drain, only driven low after reset completes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_fetch_strobe_n <= 1'b1;
      instr_fetch_oe_b <= 1'b1;
    end else begin
      instr_fetch_strobe_n <= ~(resetDone & instr_first_cycle);
      instr_fetch_oe_b <= ~(resetDone & instr_first_cycle);
    end
  end

  // ==========================================================================
  // Registered alternate inputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_sync <= '0;
      port_b_sync <= '0;
      port_c_sync <= '0;
      port_d_sync <= '0;
      bus_rdata <= '0;
      capture_in <= '0;
      capture_in_4 <= 1'b0;
      pulse_accum_in <= 1'b0;
      serial_rx <= 1'b1;
      spi_miso_in <= 1'b0;
      spi_mosi_in <= 1'b0;
      spi_sck_in <= 1'b0;
      spi_ss_in <= 1'b1;
    end else begin
      port_a_sync <= paSync;
      port_b_sync <= pbSync;
      port_c_sync <= pcSync;
      port_d_sync <= pdSync;
      bus_rdata <= pcSync;
      capture_in <= {paSync[0], paSync[1], paSync[2]};
      capture_in_4 <= paSync[3] & capture_4_select;
      pulse_accum_in <= paSync[7];
      serial_rx <= pdSync[PD_RX_POS];
      spi_miso_in <= pdSync[PD_MISO_POS];
      spi_mosi_in <= pdSync[PD_MOSI_POS];
      spi_sck_in <= pdSync[PD_SCK_POS];
      spi_ss_in <= pdSync[PD_SS_POS];
    end
  end
endmodule
`default_nettype wire

/* File: mpfm_pin_mux_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module mpfm_pin_mux_checker (
  input wire logic sys_clk, // E clock
  input wire logic rst_b, // Chip reset
  input wire logic mode_wr, // Mode write strobe
  input wire logic [1:0] mode_wdata, // New mode bits
  input wire logic special_mode_bit, // Special flag
  input wire logic mode_a_latch_bit, // A bit
  input wire logic instr_first_cycle, // First cycle
  input wire logic instr_fetch_strobe_n, // Fetch level
  input wire logic instr_fetch_oe_b, // Fetch enable
  input wire logic [15:0] bus_addr, // Bus address
  input wire logic [7:0] bus_wdata, // Write data
  input wire logic bus_read, // Read transfer
  input wire logic bus_addr_phase, // Address phase
  input wire logic [7:0] port_b_gpio_dir, // Port B direction
  input wire logic [7:0] port_d_gpio_dir, // Port D direction
  input wire logic serial_tx, // Transmit data
  input wire logic serial_tx_en, // Transmit enable
  input wire logic [7:0] port_a_oe_b, // Port A enable
  input wire logic [7:0] port_b_lines, // Port B drive
  input wire logic [7:0] port_b_oe_b, // Port B enable
  input wire logic [7:0] port_c_lines, // Port C drive
  input wire logic [7:0] port_c_oe_b, // Port C enable
  input wire logic [7:0] port_d_lines, // Port D drive
  input wire logic [7:0] port_d_oe_b // Port D enable
);
  // ==========================================================================
  // Pin function checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_mode_write: assert property (mode_wr && $past(rst_b) |=>
    {special_mode_bit, mode_a_latch_bit} == $past(mode_wdata)) else $error("mode write lost");
  chk_fetch_low: assert property ($past(rst_b) && instr_first_cycle |=>
    !instr_fetch_oe_b && !instr_fetch_strobe_n) else $error("fetch indicator not low");
  chk_fetch_idle: assert property (!instr_first_cycle |=>
    instr_fetch_oe_b) else $error("fetch indicator held low");
  chk_high_addr: assert property (mode_a_latch_bit |=>
    port_b_oe_b == 8'h00 && port_b_lines == $past(bus_addr[15:8])) else $error("high address");
  chk_low_addr: assert property (mode_a_latch_bit && bus_addr_phase |=>
    port_c_oe_b == 8'h00 && port_c_lines == $past(bus_addr[7:0])) else $error("low address");
  chk_write_data: assert property (mode_a_latch_bit && !bus_addr_phase && !bus_read |=>
    port_c_oe_b == 8'h00 && port_c_lines == $past(bus_wdata)) else $error("write data");
  chk_read_free: assert property (mode_a_latch_bit && !bus_addr_phase && bus_read |=>
    port_c_oe_b == 8'hff) else $error("port c not released on read");
  chk_strobe_rw: assert property (mode_a_latch_bit |=> port_d_oe_b[7:6] == 2'h0 &&
    port_d_lines[7:6] == {$past(bus_read), $past(bus_addr_phase)}) else $error("strobe or rw");
  chk_gpio_single: assert property (!mode_a_latch_bit |=>
    port_b_oe_b == ~$past(port_b_gpio_dir) && port_d_oe_b[7:6] == ~$past(port_d_gpio_dir[7:6]))
    else $error("gpio direction in single chip");
  chk_port_a_kind: assert property (rst_b |=>
    port_a_oe_b[2:0] == 3'h7 && port_a_oe_b[6:4] == 3'h0) else $error("port a pin kinds");
  chk_tx_alt: assert property (serial_tx_en |=>
    !port_d_oe_b[1] && port_d_lines[1] == $past(serial_tx)) else $error("transmit pin");
endmodule
bind mpfm_pin_mux mpfm_pin_mux_checker u_chk (.sys_clk, .rst_b, .mode_wr, .mode_wdata,
  .special_mode_bit, .mode_a_latch_bit, .instr_first_cycle, .instr_fetch_strobe_n,
  .instr_fetch_oe_b, .bus_addr, .bus_wdata, .bus_read, .bus_addr_phase, .port_b_gpio_dir,
  .port_d_gpio_dir, .serial_tx, .serial_tx_en, .port_a_oe_b, .port_b_lines, .port_b_oe_b,
  .port_c_lines, .port_c_oe_b, .port_d_lines, .port_d_oe_b);
`default_nettype wire

/* File: mpfm_pkg.sv */
`default_nettype none
package mpfm_pkg;
  // ==========================================================================
  // Operating modes
  typedef enum logic [1:0] {
    MPFM_SINGLE_CHIP,
    MPFM_EXPANDED,
    MPFM_BOOTSTRAP,
    MPFM_TEST
  } mpfm_mode_e;
  // ==========================================================================
  // Latched mode bit positions and reset values
  localparam int MODE_A_LATCH_POS = 0;
  localparam int SPECIAL_MODE_POS = 1;
  localparam logic [1:0] MODE_BITS_RESET = 2'h0;
  // ==========================================================================
  // Port widths and pin positions
  localparam int PORT_WIDTH = 8;
  localparam int PD_RX_POS = 0;
  localparam int PD_TX_POS = 1;
  localparam int PD_MISO_POS = 2;
  localparam int PD_MOSI_POS = 3;
  localparam int PD_SCK_POS = 4;
  localparam int PD_SS_POS = 5;
  localparam int PD_STROBE_POS = 6;
  localparam int PD_RW_POS = 7;
  localparam int PA_BIDIR_MASK = 8'h88;
  localparam int PA_OUT_MASK = 8'h70;
  localparam int PA_IN_MASK = 8'h07;
  localparam logic [7:0] RESET_OE_B = 8'hff;
  localparam logic [7:0] RESET_DATA = 8'h00;
endpackage
`default_nettype wire

/* File: mpfm_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module mpfm_sync import mpfm_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,          // System clock
  input wire logic rst_b,            // Active-low reset, not used by the stages
  input wire logic [WIDTH-1:0] din,  // Asynchronous input
  output logic [WIDTH-1:0] dout      // Synchronised output
);
  logic [WIDTH-1:0] stage1;

  // No reset: pins keep settling while reset is held, so mode capture sees them
  always_ff @(posedge sys_clk) begin
    stage1 <= din;
    dout <= stage1;
  end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk, rst_b, mode_select_a, mode_select_b, mode_wr, instr_first_cycle, bus_read;
  logic bus_addr_phase, serial_tx, serial_tx_en, spi_mosi_out, spi_miso_out, spi_sck_out;
  logic spi_en, spi_master, capture_4_select, special_mode_bit, mode_a_latch_bit, serial_rx;
  logic instr_fetch_strobe_n, instr_fetch_oe_b;
  logic capture_in_4, pulse_accum_in, spi_miso_in, spi_mosi_in, spi_sck_in, spi_ss_in;
  logic [7:0] port_a_sync, port_b_sync, port_c_sync, port_d_sync;
  logic [1:0] mode_wdata;
  logic [2:0] capture_in;
  logic [15:0] bus_addr;
  logic [5:1] compare_out;
  logic [4:0] compare_1_en;
  logic [3:0] compare_pin_en;
  logic [7:0] bus_wdata, bus_rdata, port_a_gpio_out, port_a_gpio_dir, port_b_gpio_out;
  logic [7:0] port_b_gpio_dir, port_c_gpio_out, port_c_gpio_dir, port_d_gpio_out;
  logic [7:0] port_d_gpio_dir, port_a_in, port_b_in, port_c_in, port_d_in, port_a_lines;
  logic [7:0] port_a_oe_b, port_b_lines, port_b_oe_b, port_c_lines, port_c_oe_b;
  logic [7:0] port_d_lines, port_d_oe_b;
  int nMismatch = 0;
  int samplesChecked = 0;
  // ==========================================================================
  // Design and far side
  mpfm_pin_mux u_dut (.sys_clk, .rst_b, .mode_select_a, .mode_select_b, .mode_wr, .mode_wdata,
    .special_mode_bit, .mode_a_latch_bit, .instr_first_cycle, .instr_fetch_strobe_n,
    .instr_fetch_oe_b, .bus_addr, .bus_wdata, .bus_read, .bus_addr_phase, .bus_rdata,
    .port_a_gpio_out, .port_a_gpio_dir, .port_b_gpio_out, .port_b_gpio_dir, .port_c_gpio_out,
    .port_c_gpio_dir, .port_d_gpio_out, .port_d_gpio_dir, .compare_out, .compare_1_en,
    .compare_pin_en, .capture_4_select, .serial_tx, .serial_tx_en, .spi_mosi_out, .spi_miso_out,
    .spi_sck_out, .spi_en, .spi_master, .port_a_in, .port_b_in, .port_c_in, .port_d_in,
    .port_a_lines, .port_a_oe_b, .port_b_lines, .port_b_oe_b, .port_c_lines, .port_c_oe_b,
    .port_d_lines, .port_d_oe_b, .port_a_sync, .port_b_sync, .port_c_sync,
    .port_d_sync, .capture_in, .capture_in_4, .pulse_accum_in, .serial_rx,
    .spi_miso_in, .spi_mosi_in, .spi_sck_in, .spi_ss_in);
  mpfm_ext_mem u_mem (.sys_clk, .port_b_lines, .port_c_lines, .port_c_oe_b, .port_d_lines,
    .port_d_oe_b, .port_c_in);
  // ==========================================================================
  // Shared tasks
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic doReset(input logic a, input logic b);
    rst_b = 0;
    mode_select_a = a;
    mode_select_b = b;
    repeat (16) tick;
    rst_b = 1;
    repeat (3) tick;
    chk("mode bits", 16'({~b, a}), 16'({special_mode_bit, mode_a_latch_bit}));
  endtask
  task automatic modeWrite;
    mode_wr = 1;
    for (int i = 3; i >= 0; i--) begin
      mode_wdata = 2'(i);
      tick;
      chk("written mode", 16'(i), 16'({special_mode_bit, mode_a_latch_bit}));
    end
    mode_wr = 0;
  endtask
  task automatic setMode(input logic [1:0] m);
    mode_wdata = m;
    mode_wr = 1;
    tick;
    mode_wr = 0;
    chk("set mode", 16'(m), 16'({special_mode_bit, mode_a_latch_bit}));
  endtask
  task automatic gpioSingle;
    port_b_gpio_dir = 8'hff;
    port_b_gpio_out = 8'h5a;
    port_d_gpio_dir = 8'hc0;
    port_d_gpio_out = 8'h80;
    repeat (2) tick;
    chk("port b gpio", 16'h005a, 16'(port_b_lines));
    chk("d7 d6 gpio", 16'h0002, 16'(port_d_lines[7:6]));
  endtask
  task automatic fetchPulse;
    instr_first_cycle = 1;
    tick;
    chk("fetch low", 16'h0000, 16'({instr_fetch_strobe_n, instr_fetch_oe_b}));
    instr_first_cycle = 0;
    tick;
    chk("fetch idle", 16'h0001, 16'(instr_fetch_oe_b));
  endtask
  task automatic altFuncs;
    {serial_tx_en, spi_en, spi_master, spi_mosi_out, spi_sck_out} = 5'h1f;
    serial_tx = 0;
    capture_4_select = 1;
    port_d_gpio_dir = 8'h02;
    port_d_gpio_out = 8'h02;
    {compare_out, compare_pin_en, port_a_gpio_dir} = {5'h1e, 4'hf, 8'hff};
    {port_d_in, port_b_in, port_a_in} = {8'hd4, 8'h3c, 8'h89};
    repeat (4) tick;
    chk("tx pin", 16'h0000, 16'(port_d_lines[1]));
    chk("mosi pin", 16'h0001, 16'(port_d_lines[3]));
    chk("sck pin", 16'h0001, 16'(port_d_lines[4]));
    chk("capture 4 accum", 16'h0003, 16'({capture_in_4, pulse_accum_in}));
    chk("spi data in", 16'h0002, 16'({spi_miso_in, spi_mosi_in}));
    chk("spi clock ss in", 16'h0002, 16'({spi_sck_in, spi_ss_in}));
    chk("port a b sync", 16'h893c, 16'({port_a_sync, port_b_sync}));
    chk("port d sync", 16'h00d4, 16'(port_d_sync));
    chk("rx in", 16'h0000, 16'(serial_rx));
    chk("a4 a6 compares", 16'h0007, 16'(port_a_lines[6:4]));
    chk("captures", 16'h0004, 16'(capture_in));
    chk("a0 a2 inputs", 16'h0007, 16'(port_a_oe_b[2:0]));
  endtask
  task automatic busCyc(input logic [15:0] a, input logic rd, input logic [7:0] d);
    {bus_addr, bus_read, bus_wdata, bus_addr_phase} = {a, rd, d, 1'b1};
    tick;
    bus_addr_phase = 0;
    chk("high address", 16'(a[15:8]), 16'(port_b_lines));
    chk("low address", 16'(a[7:0]), 16'(port_c_lines));
    chk("strobe", 16'h0001, 16'(port_d_lines[6]));
    repeat (5) tick;
    if (rd) begin
      chk("read data", 16'(d), 16'(bus_rdata));
      chk("port c sync", 16'(d), 16'(port_c_sync));
    end
  endtask
  initial begin
    {mode_wr, mode_wdata, instr_first_cycle, bus_addr, bus_wdata, bus_read} = '0;
    {bus_addr_phase, serial_tx, serial_tx_en, spi_mosi_out, spi_miso_out, spi_sck_out} = '0;
    {spi_en, spi_master, capture_4_select, compare_out, compare_1_en, compare_pin_en} = '0;
    {port_a_gpio_out, port_a_gpio_dir, port_b_gpio_out, port_b_gpio_dir} = '0;
    {port_c_gpio_out, port_c_gpio_dir, port_d_gpio_out, port_d_gpio_dir} = '0;
    {port_a_in, port_b_in, port_d_in} = '0;
    for (int m = 0; m < 4; m++) doReset(m[0], ~m[1]);
    modeWrite();
    gpioSingle();
    setMode(2'h2);
    gpioSingle();
    fetchPulse();
    altFuncs();
    setMode(2'h1);
    busCyc(16'h12c4, 1'b0, 8'h3b);
    busCyc(16'hfe55, 1'b0, 8'ha6);
    busCyc(16'h12c4, 1'b1, 8'h3b);
    busCyc(16'hfe55, 1'b1, 8'ha6);
    setMode(2'h3);
    busCyc(16'h7781, 1'b0, 8'hc9);
    busCyc(16'h7781, 1'b1, 8'hc9);
    finishTest();
  end
  initial begin
    #200000;
    nMismatch++;
    finishTest();
  end
endmodule
`default_nettype wire
